// file: design/dual_counter_timer_control_regs.svh
`ifndef DUAL_COUNTER_TIMER_CONTROL_REGS_SVH
`define DUAL_COUNTER_TIMER_CONTROL_REGS_SVH

// register indices; byte address is four times the index
`define IDX_EIGHT_BIT_TIMER_CONTROL     6'h00
`define IDX_SHARED_TIMER_OUTPUT_CONTROL 6'h01
`define IDX_SIXTEEN_BIT_TIMER_CONTROL   6'h02
`define IDX_EIGHT_BIT_LOW_HOLD          6'h04
`define IDX_EIGHT_BIT_HIGH_HOLD         6'h05
`define IDX_SIXTEEN_BIT_LOW_HOLD        6'h06
`define IDX_SIXTEEN_BIT_HIGH_HOLD       6'h07

// eight and sixteen bit timer control fields; prescale and capture mask exist in the eight-bit register only
`define BIT_ENABLE       7
`define BIT_SINGLE_PASS  6
`define BIT_TIME_OUT     5
`define BIT_PRESCALE_HI  4
`define BIT_PRESCALE_LO  3
`define BIT_CAPTURE_MASK 2

// shared timer output control fields
`define BIT_DEMOD_MODE   7
`define BIT_COMBINE_HI   5
`define BIT_COMBINE_LO   4
`define BIT_SUBMODE_HI   3
`define BIT_SUBMODE_LO   2
`define BIT_FIRST_A_RISE 1
`define BIT_FIRST_B_FALL 0

// reset values
`define RST_CONTROL      8'h00
`define RST_HOLD         8'h00
`define RST_PINS         3'h7

// glitch filter widths in clock cycles per submode code
`define GLITCH_WIDTH_0   5'h00
`define GLITCH_WIDTH_1   5'h04
`define GLITCH_WIDTH_2   5'h08
`define GLITCH_WIDTH_3   5'h10

`endif

// file: design/dual_counter_timer_pkg.sv
package dual_counter_timer_pkg;

    typedef enum logic [1:0] {
        submode_normal,
        submode_alternating,
        submode_force_low,
        submode_force_high
    } submode_e;

    typedef enum logic [1:0] {
        combine_and,
        combine_or,
        combine_nor,
        combine_nand
    } combine_e;

    typedef enum logic [1:0] {
        edge_falling,
        edge_rising,
        edge_both,
        edge_both_alt
    } edge_select_e;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } avalon_req_s;

    typedef struct packed {
        logic eight_bit_timer_output;
        logic sixteen_bit_timer_output;
        logic combined_timer_output;
    } timer_pins_s;

endpackage

// file: design/dual_counter_timer_control.sv
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`include "dual_counter_timer_control_regs.svh"
`default_nettype none

module dual_counter_timer_control (
    input  wire logic                               clk,
    input  wire logic                               sys_rst,
    input  wire dual_counter_timer_pkg::avalon_req_s avs_req,
    output logic [31:0]                             avs_readdata,
    output logic                                    avs_waitrequest,
    input  wire logic                               demod_input,
    output dual_counter_timer_pkg::timer_pins_s     timer_pins,
    output logic                                    capture_irq
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic reg_hit(input logic [7:0] addr, input logic [5:0] idx);
        reg_hit = (addr[1:0] == 2'h0) && (addr[7:2] == idx);
    endfunction

    function automatic logic combine(input logic [1:0] sel, input logic a, input logic b);
        logic r;
        r = 1'b0;
        unique case (dual_counter_timer_pkg::combine_e'(sel))
            dual_counter_timer_pkg::combine_and:  r = a & b;
            dual_counter_timer_pkg::combine_or:   r = a | b;
            dual_counter_timer_pkg::combine_nor:  r = ~(a | b);
            dual_counter_timer_pkg::combine_nand: r = ~(a & b);
        endcase
        combine = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0]  ctl8;
    logic [7:0]  ctl_shared;
    logic [7:0]  ctl16;
    logic [7:0]  hold8_low;
    logic [7:0]  hold8_high;
    logic [7:0]  hold16_low;
    logic [7:0]  hold16_high;
    logic        bus_ack;
    logic [2:0]  prescale_count;
    logic [7:0]  count8;
    logic [15:0] count16;
    logic        started8;
    logic        started16;
    logic        out8;
    logic        out16;
    logic        filt_level;
    logic [4:0]  filt_count;
    logic        prev_level;

    logic [7:0]  next_ctl8;
    logic [7:0]  next_ctl_shared;
    logic [7:0]  next_ctl16;
    logic [7:0]  next_hold8_low;
    logic [7:0]  next_hold8_high;
    logic [7:0]  next_hold16_low;
    logic [7:0]  next_hold16_high;
    logic        next_bus_ack;
    logic [31:0] next_readdata;
    logic [2:0]  next_prescale_count;
    logic [7:0]  next_count8;
    logic [15:0] next_count16;
    logic        next_started8;
    logic        next_started16;
    logic        next_out8;
    logic        next_out16;
    logic        next_filt_level;
    logic [4:0]  next_filt_count;
    logic        next_prev_level;
    logic        next_capture_irq;
    dual_counter_timer_pkg::timer_pins_s next_pins;

    logic        bus_req;
    logic        wr_go;
    logic        demod;
    logic [1:0]  submode;
    logic        tick;
    logic        tc8;
    logic        tc16;
    logic        forced16;
    logic [4:0]  glitch_width;
    logic        rise_seen;
    logic        fall_seen;
    logic        edge_seen;

    ////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle, then the access completes
    assign bus_req         = avs_req.read | avs_req.write;
    assign avs_waitrequest = bus_req & ~bus_ack;
    assign wr_go           = avs_req.write & bus_ack & avs_req.byteenable[0];

    assign demod   = ctl_shared[`BIT_DEMOD_MODE];
    assign submode = ctl_shared[`BIT_SUBMODE_HI:`BIT_SUBMODE_LO];

    always_comb begin
        next_bus_ack  = bus_req & ~bus_ack;
        next_readdata = avs_readdata;
        if (avs_req.read && !bus_ack) begin
            next_readdata = 32'h0000_0000;
            if (reg_hit(avs_req.address, `IDX_EIGHT_BIT_TIMER_CONTROL)) begin
                next_readdata[7:0] = {ctl8[7:2], 2'h0};
            end
            if (reg_hit(avs_req.address, `IDX_SHARED_TIMER_OUTPUT_CONTROL)) begin
                next_readdata[7:0] = {ctl_shared[7], 1'b0, ctl_shared[5:0]};
            end
            if (reg_hit(avs_req.address, `IDX_SIXTEEN_BIT_TIMER_CONTROL)) begin
                next_readdata[7:0] = {ctl16[7:5], 5'h00};
            end
            if (reg_hit(avs_req.address, `IDX_EIGHT_BIT_LOW_HOLD)) begin
                next_readdata[7:0] = hold8_low;
            end
            if (reg_hit(avs_req.address, `IDX_EIGHT_BIT_HIGH_HOLD)) begin
                next_readdata[7:0] = hold8_high;
            end
            if (reg_hit(avs_req.address, `IDX_SIXTEEN_BIT_LOW_HOLD)) begin
                next_readdata[7:0] = hold16_low;
            end
            if (reg_hit(avs_req.address, `IDX_SIXTEEN_BIT_HIGH_HOLD)) begin
                next_readdata[7:0] = hold16_high;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // prescaler shared by both timers
    always_comb begin
        next_prescale_count = prescale_count + 3'h1;
        unique case (ctl8[`BIT_PRESCALE_HI:`BIT_PRESCALE_LO])
            2'h0: tick = 1'b1;
            2'h1: tick = (prescale_count[0] == 1'b1);
            2'h2: tick = (prescale_count[1:0] == 2'h3);
            2'h3: tick = (prescale_count == 3'h7);
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // demodulation input: glitch filter and edge detect
    always_comb begin
        unique case (submode)
            2'h0: glitch_width = `GLITCH_WIDTH_0;
            2'h1: glitch_width = `GLITCH_WIDTH_1;
            2'h2: glitch_width = `GLITCH_WIDTH_2;
            2'h3: glitch_width = `GLITCH_WIDTH_3;
        endcase
        next_filt_level = filt_level;
        next_filt_count = 5'h00;
        if (demod_input != filt_level) begin
            if (filt_count >= glitch_width) begin
                next_filt_level = demod_input;
            end else begin
                next_filt_count = filt_count + 5'h01;
            end
        end
        next_prev_level = filt_level;
        rise_seen = 1'b0;
        fall_seen = 1'b0;
        if (demod) begin
            unique case (dual_counter_timer_pkg::edge_select_e'(ctl_shared[`BIT_COMBINE_HI:`BIT_COMBINE_LO]))
                dual_counter_timer_pkg::edge_falling: begin
                    fall_seen = prev_level & ~filt_level;
                end
                dual_counter_timer_pkg::edge_rising: begin
                    rise_seen = ~prev_level & filt_level;
                end
                dual_counter_timer_pkg::edge_both, dual_counter_timer_pkg::edge_both_alt: begin
                    fall_seen = prev_level & ~filt_level;
                    rise_seen = ~prev_level & filt_level;
                end
            endcase
        end
        edge_seen        = rise_seen | fall_seen;
        next_capture_irq = edge_seen & ctl8[`BIT_CAPTURE_MASK];
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers and both timers
    always_comb begin
        next_ctl8        = ctl8;
        next_ctl_shared  = ctl_shared;
        next_ctl16       = ctl16;
        next_hold8_low   = hold8_low;
        next_hold8_high  = hold8_high;
        next_hold16_low  = hold16_low;
        next_hold16_high = hold16_high;
        next_count8      = count8;
        next_count16     = count16;
        next_started8    = started8;
        next_started16   = started16;
        next_out8        = out8;
        next_out16       = out16;
        forced16         = submode[1] & ~demod;
        tc8              = 1'b0;
        tc16             = 1'b0;

        // software writes; time-out flags clear on 1, set wins below
        if (wr_go) begin
            if (reg_hit(avs_req.address, `IDX_EIGHT_BIT_TIMER_CONTROL)) begin
                next_ctl8[7:6] = avs_req.writedata[7:6];
                next_ctl8[4:2] = avs_req.writedata[4:2];
                if (avs_req.writedata[`BIT_TIME_OUT]) begin
                    next_ctl8[`BIT_TIME_OUT] = 1'b0;
                end
            end
            if (reg_hit(avs_req.address, `IDX_SIXTEEN_BIT_TIMER_CONTROL)) begin
                next_ctl16[7:6] = avs_req.writedata[7:6];
                if (avs_req.writedata[`BIT_TIME_OUT]) begin
                    next_ctl16[`BIT_TIME_OUT] = 1'b0;
                end
            end
            if (reg_hit(avs_req.address, `IDX_SHARED_TIMER_OUTPUT_CONTROL)) begin
                next_ctl_shared[7:2] = avs_req.writedata[7:2];
                if (demod) begin
                    next_ctl_shared[1:0] = ctl_shared[1:0] & ~avs_req.writedata[1:0];
                end else begin
                    next_ctl_shared[1:0] = avs_req.writedata[1:0];
                end
            end
            if (reg_hit(avs_req.address, `IDX_EIGHT_BIT_LOW_HOLD)) begin
                next_hold8_low = avs_req.writedata[7:0];
            end
            if (reg_hit(avs_req.address, `IDX_EIGHT_BIT_HIGH_HOLD)) begin
                next_hold8_high = avs_req.writedata[7:0];
            end
            if (reg_hit(avs_req.address, `IDX_SIXTEEN_BIT_LOW_HOLD)) begin
                next_hold16_low = avs_req.writedata[7:0];
            end
            if (reg_hit(avs_req.address, `IDX_SIXTEEN_BIT_HIGH_HOLD)) begin
                next_hold16_high = avs_req.writedata[7:0];
            end
        end

        // edge flags share the initial-level bits in demodulation mode
        if (rise_seen) begin
            next_ctl_shared[`BIT_FIRST_A_RISE] = 1'b1;
        end
        if (fall_seen) begin
            next_ctl_shared[`BIT_FIRST_B_FALL] = 1'b1;
        end

        // eight-bit timer
        if (!ctl8[`BIT_ENABLE]) begin
            next_started8 = 1'b0;
            next_out8     = ~ctl_shared[`BIT_FIRST_A_RISE];
        end else if (!started8) begin
            next_started8 = 1'b1;
            next_out8     = ctl_shared[`BIT_FIRST_A_RISE];
            next_count8   = ctl_shared[`BIT_FIRST_A_RISE] ? hold8_high : hold8_low;
        end else if (tick) begin
            if (count8 == 8'h00) begin
                tc8         = 1'b1;
                next_out8   = ~out8;
                next_count8 = out8 ? hold8_low : hold8_high;
            end else begin
                next_count8 = count8 - 8'h01;
            end
        end

        // sixteen-bit timer
        if (!ctl16[`BIT_ENABLE]) begin
            next_started16 = 1'b0;
            next_out16     = ~ctl_shared[`BIT_FIRST_B_FALL];
        end else if (!started16) begin
            next_started16 = 1'b1;
            next_out16     = ctl_shared[`BIT_FIRST_B_FALL];
            next_count16   = {hold16_high, hold16_low};
        end else if (tick) begin
            if (count16 == 16'h0000) begin
                tc16         = 1'b1;
                next_out16   = ~out16;
                next_count16 = {hold16_high, hold16_low};
            end else begin
                next_count16 = count16 - 16'h0001;
            end
        end
        if (forced16) begin
            next_out16 = submode[0];
        end

        // terminal count effects
        if (tc8) begin
            next_ctl8[`BIT_TIME_OUT] = 1'b1;
            if (ctl8[`BIT_SINGLE_PASS]) begin
                next_ctl8[`BIT_ENABLE] = 1'b0;
            end
        end
        if (tc16) begin
            next_ctl16[`BIT_TIME_OUT] = 1'b1;
            if (ctl16[`BIT_SINGLE_PASS]) begin
                next_ctl16[`BIT_ENABLE] = 1'b0;
            end
        end
        // alternating hand-over, only while that submode is selected
        if (!demod && dual_counter_timer_pkg::submode_e'(submode) == dual_counter_timer_pkg::submode_alternating) begin
            if (tc8) begin
                next_ctl8[`BIT_ENABLE]  = 1'b0;
                next_ctl16[`BIT_ENABLE] = 1'b1;
            end else if (tc16) begin
                next_ctl16[`BIT_ENABLE] = 1'b0;
                next_ctl8[`BIT_ENABLE]  = 1'b1;
            end
        end

        next_pins.eight_bit_timer_output    = next_out8;
        next_pins.sixteen_bit_timer_output  = next_out16;
        next_pins.combined_timer_output     = demod ? 1'b0 :
            combine(next_ctl_shared[`BIT_COMBINE_HI:`BIT_COMBINE_LO], next_out8, next_out16);
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctl8           <= `RST_CONTROL;
            ctl_shared     <= `RST_CONTROL;
            ctl16          <= `RST_CONTROL;
            hold8_low      <= `RST_HOLD;
            hold8_high     <= `RST_HOLD;
            hold16_low     <= `RST_HOLD;
            hold16_high    <= `RST_HOLD;
            bus_ack        <= 1'b0;
            avs_readdata   <= 32'h0000_0000;
            prescale_count <= 3'h0;
            count8         <= 8'h00;
            count16        <= 16'h0000;
            started8       <= 1'b0;
            started16      <= 1'b0;
            out8           <= 1'b1;
            out16          <= 1'b1;
            filt_level     <= 1'b0;
            filt_count     <= 5'h00;
            prev_level     <= 1'b0;
            capture_irq    <= 1'b0;
            timer_pins     <= `RST_PINS;
        end else begin
            ctl8           <= next_ctl8;
            ctl_shared     <= next_ctl_shared;
            ctl16          <= next_ctl16;
            hold8_low      <= next_hold8_low;
            hold8_high     <= next_hold8_high;
            hold16_low     <= next_hold16_low;
            hold16_high    <= next_hold16_high;
            bus_ack        <= next_bus_ack;
            avs_readdata   <= next_readdata;
            prescale_count <= next_prescale_count;
            count8         <= next_count8;
            count16        <= next_count16;
            started8       <= next_started8;
            started16      <= next_started16;
            out8           <= next_out8;
            out16          <= next_out16;
            filt_level     <= next_filt_level;
            filt_count     <= next_filt_count;
            prev_level     <= next_prev_level;
            capture_irq    <= next_capture_irq;
            timer_pins     <= next_pins;
        end
    end

endmodule // dual_counter_timer_control

`default_nettype wire

// file: verification/dual_counter_timer_control_props.sv
`timescale 1ns/1ns
`default_nettype none

module dual_counter_timer_control_props (
    input  wire logic                                clk,
    input  wire logic                                sys_rst,
    input  wire dual_counter_timer_pkg::avalon_req_s avs_req,
    input  wire logic [31:0]                         avs_readdata,
    input  wire logic                                avs_waitrequest,
    input  wire logic                                demod_input,
    input  wire dual_counter_timer_pkg::timer_pins_s timer_pins,
    input  wire logic                                capture_irq
);
    logic       req;
    logic       bad;
    logic       last_in;
    logic [5:0] quiet;
    logic [5:0] next_quiet;

    assign req = avs_req.read | avs_req.write;
    assign bad = (avs_req.address[1:0] != 2'h0) || (avs_req.address[7:2] == 6'h03) || (avs_req.address[7:2] > 6'h07);

    // cycles since the demodulation input last moved
    always_comb begin
        next_quiet = (demod_input != last_in) ? 6'h00 : quiet + {5'h00, quiet != 6'h3f};
    end
    always_ff @(posedge clk) begin
        quiet   <= sys_rst ? 6'h00 : next_quiet;
        last_in <= demod_input;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_wait_first: assert property ($rose(req) |-> avs_waitrequest)
        else $error("new request got no wait cycle");
    a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait lasted more than one cycle");
    a_wait_idle: assert property (!req |-> !avs_waitrequest)
        else $error("wait raised with no request");
    a_read_upper: assert property (avs_readdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    a_rdata_hold: assert property (!avs_req.read |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    a_unmapped_zero: assert property (avs_req.read && !avs_waitrequest && bad |-> avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");
    a_irq_pulse: assert property (capture_irq |=> !capture_irq)
        else $error("capture interrupt longer than one cycle");
    a_irq_quiet: assert property (quiet == 6'h3f |-> !capture_irq)
        else $error("capture interrupt with quiet input");
    a_reset_out: assert property (disable iff (1'b0) sys_rst |=> timer_pins == 3'b111 && !capture_irq)
        else $error("outputs wrong after reset");

    cover property (capture_irq);
    cover property (avs_req.read && !avs_waitrequest);
    cover property ($fell(timer_pins.eight_bit_timer_output));
endmodule // dual_counter_timer_control_props

bind dual_counter_timer_control dual_counter_timer_control_props dual_counter_timer_control_props_i (
    .clk(clk),
    .sys_rst(sys_rst),
    .avs_req(avs_req),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .demod_input(demod_input),
    .timer_pins(timer_pins),
    .capture_irq(capture_irq)
);

`default_nettype wire

// file: verification/demod_line_model.sv
`timescale 1ns/1ns
`default_nettype none

module demod_line_model (
    input  wire logic clk,
    output var  logic demod_input
);
    initial demod_input = 1'b0;

    task automatic set_level(input logic v);
        @(posedge clk);
        demod_input <= v;
    endtask

    // inverted pulse of n cycles on the line
    task automatic glitch(input int n);
        set_level(!demod_input);
        repeat (n) @(posedge clk);
        demod_input <= !demod_input;
    endtask
endmodule // demod_line_model

`default_nettype wire

// file: verification/tb_dual_counter_timer_control.sv
`timescale 1ns/1ns
`include "dual_counter_timer_control_regs.svh"
`default_nettype none

module tb_dual_counter_timer_control;
    localparam logic [7:0] c8 = {`IDX_EIGHT_BIT_TIMER_CONTROL, 2'b00};
    localparam logic [7:0] sh = {`IDX_SHARED_TIMER_OUTPUT_CONTROL, 2'b00};
    localparam logic [7:0] c16 = {`IDX_SIXTEEN_BIT_TIMER_CONTROL, 2'b00};
    localparam logic [7:0] regs [10] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h0c, 8'h20, 8'h01};

    logic                                clk;
    logic                                sys_rst;
    dual_counter_timer_pkg::avalon_req_s avs_req;
    logic [31:0]                         avs_readdata;
    logic                                avs_waitrequest;
    logic                                demod_input;
    dual_counter_timer_pkg::timer_pins_s timer_pins;
    logic                                capture_irq;
    logic [31:0]                         exp_q[$];
    logic                                mark;
    logic [31:0]                         rv;
    logic [7:0]                          d;
    logic                                e8;
    logic                                e16;
    logic                                ec;
    int                                  fails;
    int                                  n_tests;
    int                                  irqs;
    int                                  t;
    int                                  lim;

    dual_counter_timer_control dual_counter_timer_control_i (.clk(clk), .sys_rst(sys_rst), .avs_req(avs_req),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .demod_input(demod_input),
        .timer_pins(timer_pins), .capture_irq(capture_irq));
    demod_line_model demod_line_model_i (.clk(clk), .demod_input(demod_input));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, want, seen);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] dat, input logic m);
        @(posedge clk);
        avs_req <= '{read: !w, write: w, address: a, writedata: {24'h000000, dat}, byteenable: 4'hf};
        mark <= m;
        lim = 0;
        do begin
            @(posedge clk);
            lim++;
        end while (avs_waitrequest && lim < 50);
        rv = avs_readdata;
        if (avs_waitrequest) begin
            fails++;
            close_out();
        end
        avs_req <= '0;
        mark <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        bus(1'b1, a, dat, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({24'h000000, e});
        bus(1'b0, a, 8'h00, 1'b1);
    endtask

    task automatic pin(input logic [2:0] e);
        repeat (3) @(negedge clk);
        check("pins", {29'h0, timer_pins}, {29'h0, e});
    endtask

    // read results and interrupt pulses
    always @(negedge clk) begin
        if (avs_req.read && !avs_waitrequest && mark) check("read", avs_readdata, exp_q.pop_front());
        if (capture_irq) irqs++;
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst = 1'b1;
        avs_req = '0;
        mark = 1'b0;
        fails = 0;
        n_tests = 0;
        irqs = 0;
        rv = $urandom(30);
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        pin(3'b111);
        foreach (regs[i]) rd(regs[i], 8'h00);
        for (int i = 3; i < 10; i++) begin
            d = 8'($urandom);
            wr(regs[i], d);
            rd(regs[i], (i < 7) ? d : 8'h00);
        end
        wr(c8, 8'h3f);
        rd(c8, 8'h1c);
        wr(c8, 8'h00);
        for (int k = 0; k < 16; k++) begin
            wr(sh, {2'h0, 2'(k >> 2), 2'h0, 2'(k)});
            e8 = !k[1];
            e16 = !k[0];
            case (k[3:2])
                2'd0: ec = e8 & e16;
                2'd1: ec = e8 | e16;
                2'd2: ec = !(e8 | e16);
                default: ec = !(e8 & e16);
            endcase
            pin({e8, e16, ec});
        end
        wr(sh, 8'h0d);
        pin(3'b111);
        wr(sh, 8'h08);
        pin(3'b100);
        wr(h8(1), 8'h07);
        wr(h8(0), 8'h07);
        wr(sh, 8'h02);
        for (int p = 0; p < 4; p++) begin
            wr(c8, {5'b11000, 3'h0} | (8'(p) << 3));
            t = 0;
            do begin
                @(negedge clk);
                t++;
            end while (!timer_pins.eight_bit_timer_output && t < 4);
            check("start", 32'(t < 4), 32'h1);
            t = 0;
            do begin
                @(negedge clk);
                t++;
            end while (timer_pins.eight_bit_timer_output && t < 100);
            check("prescale", 32'(t >= (7 << p) && t <= (8 << p) + 2), 32'h1);
            rd(c8, 8'h60 | (8'(p) << 3));
            wr(c8, 8'h40 | (8'(p) << 3));
            rd(c8, 8'h60 | (8'(p) << 3));
            wr(c8, 8'h60 | (8'(p) << 3));
            rd(c8, 8'h40 | (8'(p) << 3));
        end
        wr(c8, 8'h80);
        e8 = timer_pins.eight_bit_timer_output;
        t = 0;
        repeat (60) begin
            @(negedge clk);
            if (timer_pins.eight_bit_timer_output != e8) t++;
            e8 = timer_pins.eight_bit_timer_output;
        end
        check("reload", 32'(t >= 4), 32'h1);
        wr(c8, 8'h00);
        pin(3'b010);
        wr(8'h1c, 8'h00);
        wr(8'h18, 8'h30);
        wr(sh, 8'h06);
        wr(c8, 8'h80);
        t = 0;
        do begin
            bus(1'b0, c16, 8'h00, 1'b0);
            t++;
        end while (!rv[7] && t < 40);
        check("handover", {31'h0, rv[7]}, 32'h1);
        check("start16", {31'h0, timer_pins.sixteen_bit_timer_output}, 32'h0);
        rd(c8, 8'h20);
        wr(sh, 8'h02);
        repeat (60) @(posedge clk);
        rd(c8, 8'h20);
        wr(c16, 8'h00);
        wr(c8, 8'h04);
        wr(sh, 8'h80);
        for (int e = 0; e < 4; e++) begin
            wr(sh, 8'h83 | (8'(e) << 4));
            demod_line_model_i.glitch(6);
            repeat (10) @(posedge clk);
            rd(sh, 8'h80 | (8'(e) << 4) | {6'h00, e != 0, e != 1});
        end
        check("irq count", irqs, 6);
        wr(sh, 8'hab);
        demod_line_model_i.glitch(4);
        repeat (30) @(posedge clk);
        rd(sh, 8'ha8);
        demod_line_model_i.glitch(12);
        repeat (30) @(posedge clk);
        rd(sh, 8'hab);
        wr(sh, 8'hab);
        rd(sh, 8'ha8);
        wr(c8, 8'h00);
        demod_line_model_i.glitch(12);
        repeat (30) @(posedge clk);
        check("irq masked", irqs, 8);
        close_out();
    end

    function automatic logic [7:0] h8(input logic hi);
        return {hi ? `IDX_EIGHT_BIT_HIGH_HOLD : `IDX_EIGHT_BIT_LOW_HOLD, 2'b00};
    endfunction
endmodule // tb_dual_counter_timer_control

`default_nettype wire
